// *** pkg/rcs_defs.svh ***
/*
 * Register offsets, field positions, reset values and constants for the
 * rotate/sleep execution block.
 * Assumes a 32-bit Avalon-MM slave with byte addresses and word registers.
 */
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

`define RCS_ADDR_W          4
`define RCS_OFS_CTRL        4'h0
`define RCS_OFS_STATUS      4'h4
`define RCS_OFS_WREG        4'h8
`define RCS_OFS_WATCHDOG    4'hC

`define RCS_CTRL_EXEC_EN    0
`define RCS_CTRL_WAKE       1
`define RCS_CTRL_RESET      1'h1

`define RCS_STAT_CARRY      0
`define RCS_STAT_PWRDN      1
`define RCS_STAT_TMOUT      2
`define RCS_STAT_ASLEEP     3

`define RCS_CARRY_RESET     1'h0
`define RCS_PWRDN_RESET     1'h1
`define RCS_TMOUT_RESET     1'h1
`define RCS_WREG_RESET      8'h00
`define RCS_WATCHDOG_CLEAR  8'h00
`define RCS_HALT_RESET      1'h0
`define RCS_WAIT_RESET      1'h1
`define RCS_RDATA_RESET     32'h0000_0000

`endif

// *** pkg/rcs_pkg.sv ***
/*
 * Types for the rotate/sleep execution block.
 * Assumes the defines header is compiled alongside.
 */
`default_nettype none
package rcs_pkg;

   typedef enum logic [1:0] {
      RCS_OP_NONE  = 2'h0,
      RCS_OP_ROTL  = 2'h1,
      RCS_OP_ROTR  = 2'h2,
      RCS_OP_SLEEP = 2'h3
   } rcs_op_t;

   // rotate_left_via_carry_op / rotate_right_via_carry_op
   typedef struct packed {
      logic       valid;
      rcs_op_t    op;
      logic [6:0] fileAddr;
      logic       dest;
      logic [7:0] fileData;
   } rcs_instr_t;

   typedef struct packed {
      logic       wWrite;
      logic [7:0] wData;
      logic       fWrite;
      logic [6:0] fAddr;
      logic [7:0] fData;
   } rcs_result_t;

   typedef enum logic [1:0] {
      RCS_ST_RUN   = 2'h0,
      RCS_ST_SLEEP = 2'h1
   } rcs_state_t;

endpackage
`default_nettype wire

// *** verilog/rcs_exec.sv ***
/*
 * Execution logic for rotate-left/right through carry and sleep.
 * Assumes instructions arrive decoded on the same clock from fetch, with the
 * addressed file register value already read, and an Avalon-MM master for
 * software access.
 */
`include "rcs_defs.svh"
`default_nettype none
module rcs_exec
   import rcs_pkg::*;
#(
   parameter int PRESCALE_W = 8
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire rcs_instr_t            instr,
   input  wire logic                  wakeReq,
   output var  rcs_result_t           result,
   output var  logic                  carryFlag,
   output var  logic                  powerDownFlag,
   output var  logic                  timeoutFlag,
   output var  logic                  oscHalt,
   output var  logic [7:0]            watchdogCount,
   input  wire logic [`RCS_ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output var  logic [31:0]           avs_readdata,
   output var  logic                  avs_waitrequest
);

   rcs_state_t             state_r, state_nxt;
   rcs_result_t            result_r, result_nxt;
   logic                   carry_r, carry_nxt;
   logic                   pwrDn_r, pwrDn_nxt;
   logic                   tmOut_r, tmOut_nxt;
   logic [7:0]             wreg_r, wreg_nxt;
   logic [7:0]             watchdog_r, watchdog_nxt;
   logic [PRESCALE_W-1:0]  prescale_r, prescale_nxt;
   logic                   halt_r, halt_nxt;
   logic                   execEn_r, execEn_nxt;
   logic                   wait_r, wait_nxt;
   logic [31:0]            rdata_r, rdata_nxt;

   // one comparator shape for every register select
   function automatic logic regHit(
      logic [`RCS_ADDR_W-1:0] addr,
      logic [`RCS_ADDR_W-1:0] ofs
   );
      return (addr == ofs);
   endfunction

   // returns {carry out, rotated value}; old carry fills the vacated end
   function automatic logic [8:0] rotThruCarry(
      logic       left,
      logic [7:0] val,
      logic       cin
   );
      logic [8:0] res;
      if (left) begin
         res = {val[7], val[6:0], cin};
      end else begin
         res = {val[0], cin, val[7:1]};
      end
      return res;
   endfunction

   // bus decode
   wire logic busReq    = avs_read | avs_write;
   wire logic busDone   = busReq & ~wait_r;
   wire logic wrCommit  = avs_write & ~wait_r & avs_byteenable[0];
   wire logic rdLaunch  = avs_read & wait_r;
   wire logic selCtrl   = regHit(avs_address, `RCS_OFS_CTRL);
   wire logic selStatus = regHit(avs_address, `RCS_OFS_STATUS);
   wire logic selWreg   = regHit(avs_address, `RCS_OFS_WREG);
   wire logic selWdog   = regHit(avs_address, `RCS_OFS_WATCHDOG);
   wire logic swCtrl    = wrCommit & selCtrl;
   wire logic swWake    = swCtrl & avs_writedata[`RCS_CTRL_WAKE];
   wire logic swWreg    = wrCommit & selWreg;

   wire logic asleep    = (state_r == RCS_ST_SLEEP);
   wire logic run       = instr.valid & execEn_r & ~asleep;
   wire logic doRotL    = run & (instr.op == RCS_OP_ROTL);
   wire logic doRotR    = run & (instr.op == RCS_OP_ROTR);
   wire logic doSleep   = run & (instr.op == RCS_OP_SLEEP);
   wire logic doRot     = doRotL | doRotR;

   wire logic [8:0] rotRes = rotThruCarry(doRotL, instr.fileData, carry_r);
   wire logic [7:0] rotVal = rotRes[7:0];
   wire logic       rotCy  = rotRes[8];

   wire logic [PRESCALE_W-1:0] preOne = {{(PRESCALE_W-1){1'b0}}, 1'b1};
   wire logic preWrap = &prescale_r;

   logic [31:0] rdataSel;
   always_comb begin
      rdataSel = 32'h0000_0000;
      if (selCtrl) begin
         rdataSel[`RCS_CTRL_EXEC_EN] = execEn_r;
      end else if (selStatus) begin
         rdataSel[`RCS_STAT_CARRY]  = carry_r;
         rdataSel[`RCS_STAT_PWRDN]  = pwrDn_r;
         rdataSel[`RCS_STAT_TMOUT]  = tmOut_r;
         rdataSel[`RCS_STAT_ASLEEP] = asleep;
      end else if (selWreg) begin
         rdataSel[7:0] = wreg_r;
      end else if (selWdog) begin
         rdataSel[7:0] = watchdog_r;
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         RCS_ST_RUN: begin
            if (doSleep) begin
               state_nxt = RCS_ST_SLEEP;
            end
         end
         RCS_ST_SLEEP: begin
            if (wakeReq | swWake) begin
               state_nxt = RCS_ST_RUN;
            end
         end
         default: state_nxt = RCS_ST_RUN;
      endcase
   end

   always_comb begin
      result_nxt        = '0;
      result_nxt.fAddr  = instr.fileAddr;
      result_nxt.wData  = rotVal;
      result_nxt.fData  = rotVal;
      result_nxt.wWrite = doRot & ~instr.dest;
      result_nxt.fWrite = doRot & instr.dest;
   end

   // only carry among status bits moves on a rotate
   assign carry_nxt = doRot ? rotCy : carry_r;
   assign pwrDn_nxt = doSleep ? 1'b0 : pwrDn_r;
   assign tmOut_nxt = doSleep ? 1'b1 : tmOut_r;

   // halt registered from the next state, so the pin sees no decode glitch
   assign halt_nxt  = (state_nxt == RCS_ST_SLEEP);

   // software writes lose to a same-cycle rotate into the accumulator
   assign wreg_nxt = result_nxt.wWrite ? rotVal :
                     swWreg ? avs_writedata[7:0] : wreg_r;

   // watchdog keeps counting in sleep and wraps past FFh; nothing raises a timeout from it
   assign prescale_nxt = doSleep ? '0 : prescale_r + preOne;
   assign watchdog_nxt = doSleep ? `RCS_WATCHDOG_CLEAR :
                         preWrap ? watchdog_r + 8'h01 : watchdog_r;

   // one wait cycle per access, so every answer comes from a flop
   assign wait_nxt   = ~(busReq & wait_r);
   assign rdata_nxt  = rdLaunch ? rdataSel : rdata_r;
   assign execEn_nxt = swCtrl ? avs_writedata[`RCS_CTRL_EXEC_EN] : execEn_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= RCS_ST_RUN;
         halt_r  <= `RCS_HALT_RESET;
      end else begin
         state_r <= state_nxt;
         halt_r  <= halt_nxt;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_r <= '0;
         carry_r  <= `RCS_CARRY_RESET;
      end else begin
         result_r <= result_nxt;
         carry_r  <= carry_nxt;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwrDn_r <= `RCS_PWRDN_RESET;
         tmOut_r <= `RCS_TMOUT_RESET;
      end else begin
         pwrDn_r <= pwrDn_nxt;
         tmOut_r <= tmOut_nxt;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wreg_r <= `RCS_WREG_RESET;
      end else begin
         wreg_r <= wreg_nxt;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         watchdog_r <= `RCS_WATCHDOG_CLEAR;
         prescale_r <= '0;
      end else begin
         watchdog_r <= watchdog_nxt;
         prescale_r <= prescale_nxt;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_r   <= `RCS_WAIT_RESET;
         rdata_r  <= `RCS_RDATA_RESET;
         execEn_r <= `RCS_CTRL_RESET;
      end else begin
         wait_r   <= wait_nxt;
         rdata_r  <= rdata_nxt;
         execEn_r <= execEn_nxt;
      end
   end

   assign result          = result_r;
   assign carryFlag       = carry_r;
   assign powerDownFlag   = pwrDn_r;
   assign timeoutFlag     = tmOut_r;
   assign oscHalt         = halt_r;
   assign watchdogCount   = watchdog_r;
   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = wait_r;

   wire logic unusedBits = busDone ^ (^avs_writedata[31:2]) ^ (^avs_byteenable[3:1]);

endmodule
`default_nettype wire

// *** testbench/rcs_exec_chk.sv ***
/* port assertions for rcs_exec, bound below.
   assumes one clock, rst async high, exec enable only via bus */
`default_nettype none
module rcs_exec_chk
   import rcs_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire rcs_instr_t  instr,
   input wire rcs_result_t result,
   input wire logic        carryFlag,
   input wire logic        powerDownFlag,
   input wire logic        timeoutFlag,
   input wire logic        oscHalt,
   input wire logic [7:0]  watchdogCount,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic        avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ns;
   logic execEn_r;
   // mirror of exec enable, so a disabled core never trips a check
   always_ff @(posedge clk or posedge rst) begin
      if (rst) execEn_r <= 1'b1;
      else if (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0])
         execEn_r <= avs_writedata[0];
   end
   wire go = instr.valid && execEn_r && !oscHalt;
   wire rot = go && (instr.op == RCS_OP_ROTL || instr.op == RCS_OP_ROTR);
   wire slp = go && instr.op == RCS_OP_SLEEP;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence sRot;
      rot;
   endsequence
   a_rotl_value: assert property (go && instr.op == RCS_OP_ROTL |=> result.wData ==
      {$past(instr.fileData[6:0]), $past(carryFlag)} && carryFlag == $past(instr.fileData[7]))
      else $error("rotate left value wrong");
   a_rotr_value: assert property (go && instr.op == RCS_OP_ROTR |=> result.wData ==
      {$past(carryFlag), $past(instr.fileData[7:1])} && carryFlag == $past(instr.fileData[0]))
      else $error("rotate right value wrong");
   a_dest_accum: assert property (sRot ##0 !instr.dest |=> result.wWrite && !result.fWrite)
      else $error("accumulator write missing");
   a_dest_file: assert property (sRot ##0 instr.dest |=> result.fWrite && !result.wWrite
      && result.fAddr == $past(instr.fileAddr)) else $error("file write wrong");
   a_sleep_flags: assert property (slp |=> !powerDownFlag && timeoutFlag)
      else $error("sleep status bits wrong");
   a_sleep_wdog: assert property (slp |=> watchdogCount == 8'h00)
      else $error("watchdog not cleared");
   a_sleep_halt: assert property (slp |=> oscHalt) else $error("oscillator not halted");
   a_halt_noexec: assert property (oscHalt |=> !result.wWrite && !result.fWrite)
      else $error("executed while asleep");
   a_rot_only_c: assert property (sRot |=> $stable(powerDownFlag) && $stable(timeoutFlag))
      else $error("rotate touched status");
endmodule
bind rcs_exec rcs_exec_chk rcs_exec_chk_i (.clk, .rst, .instr, .result, .carryFlag,
   .powerDownFlag, .timeoutFlag, .oscHalt, .watchdogCount, .avs_address, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_waitrequest);
`default_nettype wire

// *** testbench/rcs_fetch_model.sv ***
/* fetch stage and file register model: builds the decoded word.
   assumes every file register starts at E6h */
`default_nettype none
module rcs_fetch_model
   import rcs_pkg::*;
(
   input wire logic        clk,
   input wire logic        valid,
   input wire rcs_op_t     op,
   input wire logic [6:0]  addr,
   input wire logic        dest,
   input wire rcs_result_t result,
   output var rcs_instr_t  instr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] fileMem [128];
   initial foreach (fileMem[i]) fileMem[i] = 8'hE6;
   always @(posedge clk) begin
      if (result.fWrite) fileMem[result.fAddr] <= result.fData;
   end
   assign instr = '{valid: valid, op: op, fileAddr: addr, dest: dest, fileData: fileMem[addr]};
endmodule
`default_nettype wire

// *** testbench/test_rcs_exec.sv ***
/* bench for rcs_exec: rotates, sleep, wake and bus reads.
   assumes the fetch model and bound checker */
`default_nettype none
module test_rcs_exec
   import rcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, v = 1'b0, dst = 1'b0, wake = 1'b0;
   logic avRd = 1'b0, avWr = 1'b0, avWait;
   logic [3:0] avAddr = 4'h0;
   logic [31:0] avData = 32'h0, avQ, q;
   logic [6:0] fa = 7'h00;
   logic [7:0] wdg;
   rcs_op_t opc = RCS_OP_NONE;
   rcs_instr_t ins;
   rcs_result_t res;
   logic cf, pdf, tof, halt;
   int errors = 0, testsRun = 0;
   always #4 clk = ~clk;
   rcs_fetch_model rcs_fetch_model_i (.clk(clk), .valid(v), .op(opc), .addr(fa), .dest(dst),
      .result(res), .instr(ins));
   rcs_exec #(.PRESCALE_W(2)) rcs_exec_i (.clk(clk), .rst(rst), .instr(ins), .wakeReq(wake),
      .result(res), .carryFlag(cf), .powerDownFlag(pdf), .timeoutFlag(tof), .oscHalt(halt),
      .watchdogCount(wdg), .avs_address(avAddr), .avs_read(avRd), .avs_write(avWr),
      .avs_writedata(avData), .avs_byteenable(4'hF), .avs_readdata(avQ),
      .avs_waitrequest(avWait));
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      testsRun++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   // bus cycle held until waitrequest is seen low
   task av(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      {avWr, avRd, avAddr, avData} <= {w, !w, a, d};
      do @(posedge clk); while (avWait !== 1'b0);
      q = avQ;
      {avWr, avRd} <= 2'b00;
   endtask
   task op(input rcs_op_t o, input logic [6:0] a, input logic d);
      @(posedge clk);
      v   <= 1'b1;
      opc <= o;
      fa  <= a;
      dst <= d;
      @(posedge clk);
      v <= 1'b0;
      @(negedge clk);
   endtask
   task complete_run;
      $display("errors %0d testsRun %0d", errors, testsRun);
      if (errors == 0 && testsRun > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      complete_run;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      av(1'b0, 4'h4, 32'h0);
      chk("status", 32'h6, q);
      av(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, q);
      op(RCS_OP_ROTL, 7'h05, 1'b0);
      chk("rotl", {1'b1, 1'b1, 1'b0, 8'hCC},
          {res.wWrite, cf, res.fWrite, res.wData});
      av(1'b0, 4'h8, 32'h0);
      chk("wreg", 32'hCC, q);
      op(RCS_OP_ROTR, 7'h05, 1'b1);
      chk("rotr", {3'h2, 8'hF3, 7'h05},
          {res.wWrite, res.fWrite, cf, res.fData, res.fAddr});
      chk("rot status", 2'h3, {pdf, tof});
      op(RCS_OP_ROTL, 7'h05, 1'b1);
      chk("rotl file", {1'b1, 8'hE6}, {cf, res.fData});
      op(RCS_OP_SLEEP, 7'h00, 1'b0);
      chk("sleep", {3'h5, 8'h00}, {halt, pdf, tof, wdg});
      op(RCS_OP_ROTL, 7'h05, 1'b0);
      chk("asleep", 2'h2, {halt, res.wWrite});
      // 2-bit prescaler cleared by sleep: first count lands four clocks later
      repeat (2) @(posedge clk);
      @(negedge clk) chk("wdog run", 8'h01, wdg);
      @(posedge clk) wake <= 1'b1;
      @(posedge clk) wake <= 1'b0;
      @(negedge clk) chk("wake", 1'b0, halt);
      op(RCS_OP_SLEEP, 7'h00, 1'b0);
      av(1'b1, 4'h0, 32'h3);
      @(negedge clk) chk("bus wake", 1'b0, halt);
      // exec enable off: a rotate must leave no write behind
      av(1'b1, 4'h0, 32'h0);
      op(RCS_OP_ROTL, 7'h05, 1'b0);
      chk("disabled", 2'h0, {res.wWrite, res.fWrite});
      av(1'b0, 4'h0, 32'h0);
      chk("ctrl", 32'h0, q);
      complete_run;
   end
endmodule
`default_nettype wire
